// *** logic/sfx_pkg.sv ***
// How it works
// - Masked single overflow, nearest: signed infinity, O+P.
// - Toward minus: positive max finite, negative infinity.
// - Toward plus: positive infinity, negative max finite.
// - Toward zero: signed max finite, O+P set.
// - Unmasked single overflow: scale down 2^192, O.
// - Double overflow detected; masked same pattern, O+P.
// - Unmasked double overflow: scale down 2^1536, O.
// - Masked single underflow: bounded result, U+P if inexact.
// - Unmasked single underflow: scale up 2^192, U.
// - Masked double underflow: bounded result, U+P if inexact.
// - Unmasked double underflow: scale up 2^1536, U.
// - Narrowing conversions use single overflow/underflow checks.
// - Inexact raised for any unrepresentable result.
// - Square root and int-to-float also detect inexact.
// - Masked inexact: bounded result, precision flag set.
// - Unmasked inexact keeps masked O/U results and flags.
package sfx_pkg;

    //------------------------------------------------------------
    // Widths and formats
    //------------------------------------------------------------
    localparam int          SFX_EXP_W      = 14;                // Unbounded exponent width
    localparam int          SFX_FRAC_W     = 52;                // Fraction field, left aligned
    localparam int          SFX_SGL_FRAC_W = 23;                // Single fraction bits
    localparam int          SFX_DBL_EXP_W  = 11;                // Double exponent field
    localparam int          SFX_SGL_EXP_W  = 8;                 // Single exponent field

    typedef logic signed [SFX_EXP_W-1:0] sfx_exp_type;

    // Exponent limits and trap scaling
    localparam sfx_exp_type SFX_SGL_BIAS   = 14'h007F;          // Single bias, also largest exponent
    localparam sfx_exp_type SFX_SGL_EMIN   = 14'h3F82;          // Smallest normal single exponent
    localparam sfx_exp_type SFX_DBL_BIAS   = 14'h03FF;          // Double bias, also largest exponent
    localparam sfx_exp_type SFX_DBL_EMIN   = 14'h3C02;          // Smallest normal double exponent
    localparam sfx_exp_type SFX_SGL_SCALE  = 14'h00C0;          // Single trap scale power
    localparam sfx_exp_type SFX_DBL_SCALE  = 14'h0600;          // Double trap scale power
    localparam sfx_exp_type SFX_SGL_EMAXB  = 14'h00FE;          // Largest biased single exponent
    localparam sfx_exp_type SFX_DBL_EMAXB  = 14'h07FE;          // Largest biased double exponent
    localparam sfx_exp_type SFX_SGL_INFB   = 14'h00FF;          // Single infinity exponent
    localparam sfx_exp_type SFX_DBL_INFB   = 14'h07FF;          // Double infinity exponent

    // Operation classes, one-hot
    typedef enum logic [4:0] {
        SFX_OP_ARITH    = 5'h01,                                // Add, sub, mul, div
        SFX_OP_NARROW   = 5'h02,                                // Double to single
        SFX_OP_SQRT     = 5'h04,                                // Square root
        SFX_OP_TO_INT   = 5'h08,                                // Float to integer
        SFX_OP_FROM_INT = 5'h10                                 // Integer to float
    } sfx_op_type;

    // Request from the rounding stage
    typedef struct packed {
        logic                  valid;                           // Lane result present
        logic                  dbl;                             // Destination is double
        sfx_op_type            op;                              // Operation class
        logic                  sign;                            // Result sign
        logic                  zero;                            // Exact zero result
        logic                  special;                         // Inf or NaN, pass through
        sfx_exp_type           exp;                             // Unbounded unbiased exponent
        logic [SFX_FRAC_W-1:0] frac;                            // Rounded fraction
        logic                  inexact;                         // Unbounded rounding inexact
        logic [63:0]           bnd_word;                        // Bounded rounded result
        logic                  bnd_inexact;                     // Bounded rounding inexact
    } sfx_req_type;

    //------------------------------------------------------------
    // Register map
    //------------------------------------------------------------
    localparam logic [7:0]  SFX_REG_CS     = 8'h00;             // Control and status
    localparam logic [7:0]  SFX_REG_ISTAT  = 8'h04;             // Interrupt status
    localparam logic [7:0]  SFX_REG_IMASK  = 8'h08;             // Interrupt mask

    localparam int          SFX_CS_W       = 8;
    localparam int          SFX_CS_OF      = 0;                 // Overflow flag
    localparam int          SFX_CS_UF      = 1;                 // underflow_flag
    localparam int          SFX_CS_PF      = 2;                 // precision_flag
    localparam int          SFX_CS_OM      = 3;                 // Overflow mask
    localparam int          SFX_CS_UM      = 4;                 // Underflow mask
    localparam int          SFX_CS_PM      = 5;                 // Precision mask
    localparam int          SFX_CS_RC      = 6;                 // Rounding control, 2 bits
    localparam logic [7:0]  SFX_CS_RESET   = 8'h38;             // All masked, nearest

    localparam int          SFX_IRQ_W      = 4;
    localparam int          SFX_IRQ_OF     = 0;                 // Overflow event
    localparam int          SFX_IRQ_UF     = 1;                 // Underflow event
    localparam int          SFX_IRQ_PF     = 2;                 // Inexact event
    localparam int          SFX_IRQ_FAULT  = 3;                 // Unmasked exception event

    localparam logic [1:0]  SFX_RC_NEAR    = 2'h0;
    localparam logic [1:0]  SFX_RC_DOWN    = 2'h1;
    localparam logic [1:0]  SFX_RC_UP      = 2'h2;
    localparam logic [1:0]  SFX_RC_ZERO    = 2'h3;

endpackage

// *** logic/sfx_post_exc.sv ***
// Added by the designer: the Wishbone interface to the registers and the register addresses.
module sfx_post_exc (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Result from the rounding stage
    input  sfx_pkg::sfx_req_type   req_i,
    // Delivered result to the core
    output logic [63:0]            result_o,
    output logic                   result_valid_o,
    output logic                   fault_o,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic [31:0]            dat_o,
    output logic                   ack_o,
    // Interrupt
    output logic                   irq_o
);
    import sfx_pkg::*;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------

    // Pack sign, biased exponent and fraction into the destination word
    function automatic logic [63:0] pack_fp(
        input logic                  dbl,
        input logic                  sign,
        input sfx_exp_type           bexp,
        input logic [SFX_FRAC_W-1:0] frac
    );
        logic [63:0] w;
        w = '0;
        if (dbl) begin
            w = {sign, bexp[SFX_DBL_EXP_W-1:0], frac};
        end else begin
            w[31:0] = {sign, bexp[SFX_SGL_EXP_W-1:0], frac[SFX_FRAC_W-1 -: SFX_SGL_FRAC_W]};
        end
        return w;
    endfunction

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [SFX_CS_W-1:0]  cs;                                   // Control and sticky status
    logic [SFX_IRQ_W-1:0] istat;                                // Sticky interrupt events
    logic [SFX_IRQ_W-1:0] imask;                                // Interrupt enables
    logic [63:0]          result;                               // Delivered result
    logic                 result_valid;                         // Result strobe
    logic                 fault;                                // Exception to core
    logic [31:0]          rdata;                                // Bus read data
    logic                 ack;                                  // Bus acknowledge
    logic                 irq;                                  // Interrupt level

    logic [SFX_CS_W-1:0]  next_cs;
    logic [SFX_IRQ_W-1:0] next_istat;
    logic [SFX_IRQ_W-1:0] next_imask;
    logic [63:0]          next_result;
    logic                 next_result_valid;
    logic                 next_fault;
    logic [31:0]          next_rdata;
    logic                 next_ack;
    logic                 next_irq;

    //------------------------------------------------------------
    // Exception detection and response
    //------------------------------------------------------------
    logic                  dst_dbl;                             // Effective destination precision
    logic                  range_chk;                           // Op can over/underflow
    sfx_exp_type           emax;                                // Largest unbiased exponent
    sfx_exp_type           emin;                                // Smallest normal exponent
    sfx_exp_type           bias;                                // Exponent bias
    sfx_exp_type           scale;                               // Trap scaling power
    sfx_exp_type           maxb;                                // Largest finite biased exponent
    sfx_exp_type           infb;                                // Infinity biased exponent
    logic                  ovf;                                 // Overflow detected
    logic                  unf;                                 // Underflow detected
    logic                  to_inf;                              // Masked overflow goes to infinity
    logic                  set_of;                              // Overflow flag event
    logic                  set_uf;                              // Underflow flag event
    logic                  set_pf;                              // Precision flag event
    logic                  trap;                                // Unmasked condition
    logic [63:0]           res;                                 // Chosen result
    logic [1:0]            rc;                                  // Rounding control

    // Classify the request and pick the delivered value
    always_comb begin
        rc     = cs[SFX_CS_RC +: 2];
        set_of = 1'b0;
        set_uf = 1'b0;
        set_pf = 1'b0;
        trap   = 1'b0;
        res    = req_i.bnd_word;
        to_inf = 1'b0;
        // Narrowing checks against single limits
        dst_dbl = req_i.dbl && (req_i.op != SFX_OP_NARROW);
        // Only arithmetic and narrowing can leave the range
        case (req_i.op)
            SFX_OP_ARITH:    range_chk = 1'b1;
            SFX_OP_NARROW:   range_chk = 1'b1;
            SFX_OP_SQRT:     range_chk = 1'b0;
            SFX_OP_TO_INT:   range_chk = 1'b0;
            SFX_OP_FROM_INT: range_chk = 1'b0;
            default:         range_chk = 1'b0;
        endcase
        // Format limits
        if (dst_dbl) begin
            emax  = SFX_DBL_BIAS;
            emin  = SFX_DBL_EMIN;
            bias  = SFX_DBL_BIAS;
            scale = SFX_DBL_SCALE;
            maxb  = SFX_DBL_EMAXB;
            infb  = SFX_DBL_INFB;
        end else begin
            emax  = SFX_SGL_BIAS;
            emin  = SFX_SGL_EMIN;
            bias  = SFX_SGL_BIAS;
            scale = SFX_SGL_SCALE;
            maxb  = SFX_SGL_EMAXB;
            infb  = SFX_SGL_INFB;
        end
        // Detection on the unbounded rounded result
        ovf = req_i.valid && range_chk && !req_i.zero && !req_i.special
              && (req_i.exp > emax);
        unf = req_i.valid && range_chk && !req_i.zero && !req_i.special
              && (req_i.exp < emin);
        if (!req_i.valid) begin
            // No lane result this cycle
            res = '0;
        end else if (ovf && !cs[SFX_CS_OM]) begin
            // Unmasked overflow: scaled down result
            res    = pack_fp(dst_dbl, req_i.sign,
                             SFX_EXP_W'(req_i.exp + bias - scale), req_i.frac);
            set_of = 1'b1;
            set_pf = req_i.inexact;
            trap   = 1'b1;
        end else if (ovf) begin
            // Masked overflow: direction decides infinity or max finite
            case (rc)
                SFX_RC_NEAR: to_inf = 1'b1;
                SFX_RC_DOWN: to_inf = req_i.sign;
                SFX_RC_UP:   to_inf = !req_i.sign;
                SFX_RC_ZERO: to_inf = 1'b0;
                default:     to_inf = 1'b1;
            endcase
            if (to_inf) begin
                res = pack_fp(dst_dbl, req_i.sign, infb, '0);
            end else begin
                res = pack_fp(dst_dbl, req_i.sign, maxb, '1);
            end
            set_of = 1'b1;
            set_pf = 1'b1;
        end else if (unf && !cs[SFX_CS_UM]) begin
            // Unmasked underflow: scaled up result
            res    = pack_fp(dst_dbl, req_i.sign,
                             SFX_EXP_W'(req_i.exp + bias + scale), req_i.frac);
            set_uf = 1'b1;
            set_pf = req_i.inexact;
            trap   = 1'b1;
        end else if (unf) begin
            // Masked underflow: bounded result, flags only when inexact
            res    = req_i.bnd_word;
            set_uf = req_i.bnd_inexact;
            set_pf = req_i.bnd_inexact;
        end else begin
            // In range: bounded result, inexact for every op class
            res    = req_i.bnd_word;
            set_pf = req_i.bnd_inexact;
        end
        // Single results live in the low word only; upper word forced clear
        if (!dst_dbl) begin
            res[63:32] = '0;
        end
        // Unmasked inexact traps after masked responses are settled
        if (set_pf && !cs[SFX_CS_PM]) begin
            trap = 1'b1;
        end
    end

    //------------------------------------------------------------
    // Result and sticky state next values
    //------------------------------------------------------------
    logic        bus_req;                                       // New bus request
    logic        bus_wr;                                        // Write this cycle
    logic        bus_rd;                                        // Read this cycle
    logic [31:0] cs_wr;                                         // Merged control write
    logic [31:0] im_wr;                                         // Merged mask write

    always_comb begin
        bus_req = cyc_i && stb_i && !ack;
        bus_wr  = bus_req && we_i;
        bus_rd  = bus_req && !we_i;
        cs_wr   = lane_merge({{(32-SFX_CS_W){1'b0}}, cs}, dat_i, sel_i);
        im_wr   = lane_merge({{(32-SFX_IRQ_W){1'b0}}, imask}, dat_i, sel_i);

        // Delivered result, one cycle after the request
        next_result       = res;
        next_result_valid = req_i.valid;
        next_fault        = req_i.valid && trap;

        // Control and status: software write first, events win
        next_cs = cs;
        if (bus_wr && (adr_i == SFX_REG_CS)) begin
            next_cs = cs_wr[SFX_CS_W-1:0];
        end
        if (set_of) begin
            next_cs[SFX_CS_OF] = 1'b1;
        end
        if (set_uf) begin
            next_cs[SFX_CS_UF] = 1'b1;
        end
        if (set_pf) begin
            next_cs[SFX_CS_PF] = 1'b1;
        end

        // Interrupt mask
        next_imask = imask;
        if (bus_wr && (adr_i == SFX_REG_IMASK)) begin
            next_imask = im_wr[SFX_IRQ_W-1:0];
        end

        // Interrupt status: read clears, new events win
        next_istat = istat;
        if (bus_rd && (adr_i == SFX_REG_ISTAT)) begin
            next_istat = '0;
        end
        next_istat[SFX_IRQ_OF]    = next_istat[SFX_IRQ_OF] | set_of;
        next_istat[SFX_IRQ_UF]    = next_istat[SFX_IRQ_UF] | set_uf;
        next_istat[SFX_IRQ_PF]    = next_istat[SFX_IRQ_PF] | set_pf;
        next_istat[SFX_IRQ_FAULT] = next_istat[SFX_IRQ_FAULT] | (req_i.valid && trap);

        // Interrupt level from the next register state
        next_irq = |(next_istat & next_imask);

        // Bus answer, one cycle after the request
        next_ack   = bus_req;
        next_rdata = '0;
        if (bus_rd) begin
            case (adr_i)
                SFX_REG_CS:    next_rdata = {{(32-SFX_CS_W){1'b0}}, cs};
                SFX_REG_ISTAT: next_rdata = {{(32-SFX_IRQ_W){1'b0}}, istat};
                SFX_REG_IMASK: next_rdata = {{(32-SFX_IRQ_W){1'b0}}, imask};
                default:       next_rdata = '0;             // Unmapped reads zero
            endcase
        end
    end

    //------------------------------------------------------------
    // State registers
    //------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs           <= SFX_CS_RESET;
            istat        <= '0;
            imask        <= '0;
            result       <= '0;
            result_valid <= 1'b0;
            fault        <= 1'b0;
            rdata        <= '0;
            ack          <= 1'b0;
            irq          <= 1'b0;
        end else begin
            cs           <= next_cs;
            istat        <= next_istat;
            imask        <= next_imask;
            result       <= next_result;
            result_valid <= next_result_valid;
            fault        <= next_fault;
            rdata        <= next_rdata;
            ack          <= next_ack;
            irq          <= next_irq;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign result_o       = result;
    assign result_valid_o = result_valid;
    assign fault_o        = fault;
    assign dat_o          = rdata;
    assign ack_o          = ack;
    assign irq_o          = irq;

endmodule

// *** bench/sfx_post_exc_properties.sv ***
module sfx_post_exc_properties (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Result path
    input  sfx_pkg::sfx_req_type  req_i,
    input  wire logic [63:0]      result_o,
    input  wire logic             result_valid_o,
    input  wire logic             fault_o,
    // Bus and interrupt
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    input  wire logic [31:0]      dat_o,
    input  wire logic             ack_o,
    input  wire logic             irq_o
);
    import sfx_pkg::*;
    // -------------------------------------------------
    // Result path and bus timing
    // -------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_RES_LAT: assert property (req_i.valid |=> result_valid_o) else $error("result late");
    AST_RES_IDLE: assert property (!req_i.valid |=> !result_valid_o && !fault_o) else $error("spurious result");
    AST_FAULT_WITH: assert property (fault_o |-> result_valid_o) else $error("fault alone");
    AST_SGL_UPPER: assert property (req_i.valid && !req_i.dbl |=> result_o[63:32] == 32'h0)
        else $error("single upper word set");
    AST_SPECIAL: assert property (req_i.valid && req_i.special && req_i.dbl |=> result_o == $past(req_i.bnd_word))
        else $error("special not passed");
    AST_SQRT_PASS: assert property (req_i.valid && req_i.dbl && req_i.op == SFX_OP_SQRT
        |=> result_o == $past(req_i.bnd_word)) else $error("sqrt result wrong");
    AST_EXACT_NOFAULT: assert property (req_i.valid && req_i.op == SFX_OP_SQRT && !req_i.bnd_inexact
        |=> !fault_o) else $error("fault on exact sqrt");
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
    AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> result_valid_o || ack_o || $past(ack_o)
        || $past(result_valid_o)) else $error("irq without cause");
endmodule

bind sfx_post_exc sfx_post_exc_properties u_props (.clk_i, .rst_i, .req_i, .result_o, .result_valid_o, .fault_o,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o);

// *** bench/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sfx_pkg::*;
    // -------------------------------------------------
    // Stimulus and observed signals
    // -------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    sfx_req_type req_i = '0;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rdata;
    logic [63:0] result_o;
    logic        result_valid_o, fault_o, ack_o, irq_o, sg;
    int          error_cnt = 0, samples_checked = 0;
    always #20 clk_i = ~clk_i;
    sfx_post_exc dut (.clk_i, .rst_i, .req_i, .result_o, .result_valid_o, .fault_o,
        .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o);
    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdata = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    function automatic sfx_req_type mk(logic dbl, sfx_op_type op, logic s, sfx_exp_type e, logic [51:0] f,
        logic ix, logic [63:0] bw, logic bix, logic sp = 1'b0);
        mk = '{1'b1, dbl, op, s, 1'b0, sp, e, f, ix, bw, bix};
    endfunction
    // One lane in, answer one cycle later
    task automatic send(input sfx_req_type r, input logic [63:0] er, input logic ef);
        @(posedge clk_i);
        req_i <= r;
        @(posedge clk_i);
        req_i <= '0;
        #1;
        chk(result_valid_o, 64'h1);
        chk(result_o, er);
        chk(fault_o, ef);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_i);
        #1;
        chk(irq_o, e);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // -------------------------------------------------
    // Tests
    // -------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(SFX_REG_CS, 32'h38);
        rdchk(SFX_REG_ISTAT, 32'h0);
        rdchk(8'h0C, 32'h0);
        // Masked single overflow, every rounding mode and sign
        for (int i = 0; i < 8; i++) begin
            sg = i[0];
            wb(1'b1, SFX_REG_CS, {24'h0, 2'(i >> 1), 6'h38});
            send(mk(1'b0, sg ? SFX_OP_NARROW : SFX_OP_ARITH, sg, 14'sd200, 52'h0, 1'b0, 64'h0, 1'b0),
                {32'h0, sg, (8'h1B >> i) & 8'h1 ? 31'h7F800000 : 31'h7F7FFFFF}, 1'b0);
            rdchk(SFX_REG_CS, {24'h0, 2'(i >> 1), 6'h3D});
        end
        wb(1'b1, SFX_REG_CS, 32'hF8);
        send(mk(1'b1, SFX_OP_ARITH, 1'b1, 14'sd1100, 52'h0, 1'b0, 64'h0, 1'b0), 64'hFFEFFFFFFFFFFFFF, 1'b0);
        wb(1'b1, SFX_REG_CS, 32'h30);
        send(mk(1'b0, SFX_OP_ARITH, 1'b0, 14'sd200, 52'h8000000000000, 1'b1, 64'h0, 1'b0), 64'h43C00000, 1'b1);
        rdchk(SFX_REG_CS, 32'h35);
        wb(1'b1, SFX_REG_CS, 32'h28);
        send(mk(1'b1, SFX_OP_ARITH, 1'b0, -14'sd1100, 52'h0, 1'b0, 64'h0, 1'b0), 64'h5B30000000000000, 1'b1);
        rdchk(SFX_REG_CS, 32'h2A);
        wb(1'b1, SFX_REG_CS, 32'h38);
        send(mk(1'b0, SFX_OP_ARITH, 1'b1, -14'sd130, 52'h0, 1'b1, 64'h80000001, 1'b1), 64'h80000001, 1'b0);
        rdchk(SFX_REG_CS, 32'h3E);
        send(mk(1'b0, SFX_OP_TO_INT, 1'b0, 14'sd0, 52'h0, 1'b0, 64'h7, 1'b1), 64'h7, 1'b0);
        send(mk(1'b0, SFX_OP_FROM_INT, 1'b0, 14'sd0, 52'h0, 1'b0, 64'hFFFFFFFF4B000001, 1'b1), 64'h4B000001, 1'b0);
        // Precision unmasked beside masked overflow and on square root
        wb(1'b1, SFX_REG_CS, 32'h18);
        send(mk(1'b0, SFX_OP_ARITH, 1'b0, 14'sd200, 52'h0, 1'b0, 64'h0, 1'b0), 64'h7F800000, 1'b1);
        rdchk(SFX_REG_CS, 32'h1D);
        wb(1'b1, SFX_REG_CS, 32'h18);
        send(mk(1'b1, SFX_OP_SQRT, 1'b0, 14'sd0, 52'h0, 1'b0, 64'h3FF8000000000001, 1'b1), 64'h3FF8000000000001, 1'b1);
        send(mk(1'b1, SFX_OP_SQRT, 1'b0, 14'sd0, 52'h0, 1'b0, 64'h7FF8000000000000, 1'b0, 1'b1), 64'h7FF8000000000000, 1'b0);
        rdchk(SFX_REG_CS, 32'h1C);
        // Interrupt raised, masked, cleared
        wb(1'b1, SFX_REG_CS, 32'h38);
        wb(1'b0, SFX_REG_ISTAT, 32'h0);
        wb(1'b1, SFX_REG_IMASK, 32'h1);
        send(mk(1'b0, SFX_OP_ARITH, 1'b0, 14'sd200, 52'h0, 1'b0, 64'h0, 1'b0), 64'h7F800000, 1'b0);
        irq_is(1'b1);
        wb(1'b1, SFX_REG_IMASK, 32'h0);
        irq_is(1'b0);
        wb(1'b1, SFX_REG_IMASK, 32'h1);
        irq_is(1'b1);
        rdchk(SFX_REG_ISTAT, 32'h5);
        irq_is(1'b0);
        print_verdict();
    end
    // Hang guard, far beyond the roughly 160 cycles needed
    initial begin
        repeat (4000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
endmodule
